// ==== dws_defs.vh ====
// constants for the write burst spacing block: offsets, fields, reset values
`ifndef DWS_DEFS_VH
`define DWS_DEFS_VH

// register byte addresses
`define DWS_OFF_CTRL      6'h00
`define DWS_OFF_LAT       6'h04
`define DWS_OFF_TWTR      6'h08
`define DWS_OFF_STATUS    6'h0c
`define DWS_OFF_BEATS     6'h10
`define DWS_OFF_LASTDATA  6'h14

// ctrl fields
`define DWS_CTRL_BLMODE_LO 0
`define DWS_CTRL_BLMODE_HI 1
`define DWS_CTRL_PRE2      2
// burst length field codes
`define DWS_BL_FIXED8      2'h0
`define DWS_BL_OTF         2'h1
`define DWS_BL_FIXED4      2'h2

// lat fields
`define DWS_LAT_CWL_LO     0
`define DWS_LAT_CWL_HI     5
`define DWS_LAT_AL_LO      8
`define DWS_LAT_AL_HI      13
`define DWS_LAT_CWLMIN_LO  16
`define DWS_LAT_CWLMIN_HI  21

// twtr fields, in link clocks
`define DWS_TWTR_S_LO      0
`define DWS_TWTR_S_HI      7
`define DWS_TWTR_L_LO      8
`define DWS_TWTR_L_HI      15

// status bits
`define DWS_ST_CFGERR      0
`define DWS_ST_SPACEERR    1
`define DWS_ST_WTRERR      2
`define DWS_ST_BUSY        3

// reset values
`define DWS_RST_CTRL       32'h00000000
`define DWS_RST_LAT        32'h00090009
`define DWS_RST_TWTR       32'h00000602

// timing counts in link clocks; burst lengths in beats
`define DWS_WL_MAX         6'h3f
`define DWS_BEATS_BL8      4'h8
`define DWS_BEATS_BC4      4'h4
`define DWS_CCD_2T_BAD     16'h0005

// axi responses
`define DWS_RESP_OKAY      2'h0
`define DWS_RESP_SLVERR    2'h2

`endif

// ==== dws_write_path.v ====
// device-side write burst path with link clock sampling and axi4-lite registers
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - BL8 when fixed BL8 code or OTF with A12 high
// - OTF with A12 low gives four-beat chop
// - fixed chop code always gives four beats
// - four-clock BL8 writes stream without gap
// - five-clock spacing leaves gap between bursts
// - 2tCK nonconsecutive writes spaced six clocks
// - BL8 then OTF chop four clocks later
// - other commands accepted during write bursts
`include "dws_defs.vh"

module dws_write_path (
  input  wire        aclk,          // system clock, 250 MHz
  input  wire        aresetn,       // synchronous reset, active low
  input  wire [5:0]  s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output wire        s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write byte enables
  input  wire        s_axi_wvalid,  // write data valid
  output wire        s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [5:0]  s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output wire        s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read data valid
  input  wire        s_axi_rready,  // read data ready
  input  wire        ck_pin,        // link clock from controller
  input  wire        cs_n,          // chip select, active low
  input  wire        act_n,         // activate, active low
  input  wire        ras_n,         // row strobe, active low
  input  wire        cas_n,         // column strobe, active low
  input  wire        we_n,          // write enable, active low
  input  wire        a12,           // burst chop select
  input  wire        bg,            // bank group
  input  wire [15:0] dq,            // write data pins
  output reg         beat_valid,    // one-cycle pulse per captured beat
  output reg  [15:0] beat_data,     // captured beat
  output reg         beat_last,     // last beat of a burst
  output reg         burst_bl8,     // current burst is eight beats
  output reg         rec_start,     // pulse at first ck rise after last beat
  output reg         other_cmd      // pulse for a non-write command
);

  reg  [31:0] ctrl;
  reg  [31:0] lat;
  reg  [31:0] twtr;
  reg         space_err;
  reg         wtr_err;
  reg  [15:0] beat_cnt;
  reg  [15:0] last_data;
  reg  [23:0] pin_s1;
  reg  [23:0] pin_s2;
  reg  [23:0] pin_s3;
  reg  [23:0] pin_st;
  reg         ck_prev;
  reg  [15:0] tick;
  reg  [63:0] pend_start;
  reg  [63:0] pend_bl8;
  reg  [63:0] pend_bg;
  reg  [3:0]  beat_left;
  reg         cur_bg;
  reg         rec_pend;
  reg         rec_bg;
  reg  [15:0] last_wr_tick;
  reg         last_wr_ok;
  reg  [15:0] wend0;
  reg  [15:0] wend1;
  reg  [1:0]  wend_ok;
  reg         aw_full;
  reg         w_full;
  reg  [5:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer      i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          wmerge[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  endfunction
  function is_bl8;
    input [1:0] mode;
    input       a12_bit;
    begin
      is_bl8 = (mode == `DWS_BL_FIXED8) || ((mode == `DWS_BL_OTF) && a12_bit);
    end
  endfunction
  function [15:0] since;
    input [15:0] now;
    input [15:0] then_t;
    begin
      since = now - then_t;
    end
  endfunction
  wire [1:0]  bl_mode = ctrl[`DWS_CTRL_BLMODE_HI:`DWS_CTRL_BLMODE_LO];
  wire        pre2    = ctrl[`DWS_CTRL_PRE2];
  wire [5:0]  cwl     = lat[`DWS_LAT_CWL_HI:`DWS_LAT_CWL_LO];
  wire [5:0]  al      = lat[`DWS_LAT_AL_HI:`DWS_LAT_AL_LO];
  wire [5:0]  cwl_min = lat[`DWS_LAT_CWLMIN_HI:`DWS_LAT_CWLMIN_LO];
  wire [7:0]  twtr_s  = twtr[`DWS_TWTR_S_HI:`DWS_TWTR_S_LO];
  wire [7:0]  twtr_l  = twtr[`DWS_TWTR_L_HI:`DWS_TWTR_L_LO];
  wire [6:0]  wl_sum  = {1'b0, al} + {1'b0, cwl};
  // write latency, clamped to the delay line length
  wire [5:0]  wl      = (wl_sum > {1'b0, `DWS_WL_MAX}) ? `DWS_WL_MAX : (wl_sum == 7'h00) ? 6'h01 : wl_sum[5:0];
  wire        cfg_err = pre2 && (cwl <= cwl_min);
  wire        ck_st   = pin_st[23];
  wire        ck_rise = ck_st && !ck_prev;
  wire        ck_fall = !ck_st && ck_prev;
  wire        cmd_en  = !pin_st[22];
  wire        is_wr   = cmd_en && pin_st[21] && pin_st[20] && !pin_st[19] && !pin_st[18];
  wire        is_rd   = cmd_en && pin_st[21] && pin_st[20] && !pin_st[19] && pin_st[18];
  wire        pin_a12 = pin_st[17];
  wire        pin_bg  = pin_st[16];
  wire [15:0] pin_dq  = pin_st[15:0];
  wire [63:0] wl_bit  = 64'h1 << (wl - 6'h01);
  wire [63:0] sh_st   = pend_start >> 1;
  wire [63:0] sh_bl8  = pend_bl8 >> 1;
  wire [63:0] sh_bg   = pend_bg >> 1;
  wire        busy    = (|pend_start) || (beat_left != 4'h0);
  // three-stage sampling; a change counts once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 24'h000000;
      pin_s2 <= 24'h000000;
      pin_s3 <= 24'h000000;
      pin_st <= 24'h000000;
      ck_prev <= 1'b0;
    end else begin
      pin_s1 <= {ck_pin, cs_n, act_n, ras_n, cas_n, we_n, a12, bg, dq};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_st <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_st & (pin_s2 ^ pin_s3));
      ck_prev <= ck_st;
    end
  end

  // write scheduling and beat capture, one step per sampled ck edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 16'h0000;
      pend_start <= 64'h0;
      pend_bl8 <= 64'h0;
      pend_bg <= 64'h0;
      beat_left <= 4'h0;
      cur_bg <= 1'b0;
      rec_pend <= 1'b0;
      rec_bg <= 1'b0;
      last_wr_tick <= 16'h0000;
      last_wr_ok <= 1'b0;
      wend0 <= 16'h0000;
      wend1 <= 16'h0000;
      wend_ok <= 2'b00;
      beat_valid <= 1'b0;
      beat_data <= 16'h0000;
      beat_last <= 1'b0;
      burst_bl8 <= 1'b0;
      rec_start <= 1'b0;
      other_cmd <= 1'b0;
      beat_cnt <= 16'h0000;
      last_data <= 16'h0000;
    end else begin
      beat_valid <= 1'b0;
      beat_last <= 1'b0;
      rec_start <= 1'b0;
      other_cmd <= 1'b0;
      if (ck_rise) begin
        tick <= tick + 16'h0001;
        // delay line places the burst WL clocks out
        pend_start <= sh_st | (is_wr ? wl_bit : 64'h0);
        pend_bl8 <= (sh_bl8 & ~(is_wr ? wl_bit : 64'h0)) | ((is_wr && is_bl8(bl_mode, pin_a12)) ? wl_bit : 64'h0);
        pend_bg <= (sh_bg & ~(is_wr ? wl_bit : 64'h0)) | ((is_wr && pin_bg) ? wl_bit : 64'h0);
        if (is_wr) begin
          last_wr_tick <= tick;
          last_wr_ok <= 1'b1;
        end
        // any other command is taken in any slot
        other_cmd <= cmd_en && !is_wr;
        if (rec_pend) begin
          rec_start <= 1'b1;
          rec_pend <= 1'b0;
          if (rec_bg) begin
            wend1 <= tick;
            wend_ok[1] <= 1'b1;
          end else begin
            wend0 <= tick;
            wend_ok[0] <= 1'b1;
          end
        end
        // a new burst may start on the edge after the previous ends
        if (pend_start[0]) begin
          beat_valid <= 1'b1;
          beat_data <= pin_dq;
          last_data <= pin_dq;
          beat_cnt <= beat_cnt + 16'h0001;
          burst_bl8 <= pend_bl8[0];
          cur_bg <= pend_bg[0];
          beat_left <= (pend_bl8[0] ? `DWS_BEATS_BL8 : `DWS_BEATS_BC4) - 4'h1;
        end else if (beat_left != 4'h0) begin
          beat_valid <= 1'b1;
          beat_data <= pin_dq;
          last_data <= pin_dq;
          beat_cnt <= beat_cnt + 16'h0001;
          beat_left <= beat_left - 4'h1;
        end
      end else if (ck_fall && (beat_left != 4'h0)) begin
        beat_valid <= 1'b1;
        beat_data <= pin_dq;
        last_data <= pin_dq;
        beat_cnt <= beat_cnt + 16'h0001;
        beat_left <= beat_left - 4'h1;
        // gaps simply leave the engine idle
        if (beat_left == 4'h1) begin
          beat_last <= 1'b1;
          rec_pend <= 1'b1;
          rec_bg <= cur_bg;
        end
      end
    end
  end

  // spacing checks flag controller slips; set wins over a software clear
  wire        wr_clr    = aw_full && w_full && !s_axi_bvalid && (aw_addr == `DWS_OFF_STATUS) && w_strb[0];
  wire        space_set = ck_rise && is_wr && pre2 && last_wr_ok &&
                          (since(tick, last_wr_tick) == `DWS_CCD_2T_BAD);
  wire [15:0] gap_same  = pin_bg ? since(tick, wend1) : since(tick, wend0);
  wire [15:0] gap_other = pin_bg ? since(tick, wend0) : since(tick, wend1);
  wire        ok_same   = pin_bg ? wend_ok[1] : wend_ok[0];
  wire        ok_other  = pin_bg ? wend_ok[0] : wend_ok[1];
  wire        wtr_set   = ck_rise && is_rd &&
                          ((ok_same && (gap_same < {8'h00, twtr_l})) ||
                           (ok_other && (gap_other < {8'h00, twtr_s})));

  always @(posedge aclk) begin
    if (!aresetn) begin
      space_err <= 1'b0;
      wtr_err <= 1'b0;
    end else begin
      space_err <= space_set || (space_err && !(wr_clr && w_data[`DWS_ST_SPACEERR]));
      wtr_err <= wtr_set || (wtr_err && !(wr_clr && w_data[`DWS_ST_WTRERR]));
    end
  end

  // axi4-lite slave: address and data taken in either order, one write at a time
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire        wr_go  = aw_full && w_full && !s_axi_bvalid;
  wire        wr_map = (aw_addr == `DWS_OFF_CTRL) || (aw_addr == `DWS_OFF_LAT) ||
                       (aw_addr == `DWS_OFF_TWTR) || (aw_addr == `DWS_OFF_STATUS);
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DWS_RESP_OKAY;
      ctrl <= `DWS_RST_CTRL;
      lat <= `DWS_RST_LAT;
      twtr <= `DWS_RST_TWTR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `DWS_RESP_OKAY : `DWS_RESP_SLVERR;
        if (aw_addr == `DWS_OFF_CTRL) ctrl <= wmerge(ctrl, w_data, w_strb) & 32'h00000007;
        if (aw_addr == `DWS_OFF_LAT) lat <= wmerge(lat, w_data, w_strb) & 32'h003f3f3f;
        if (aw_addr == `DWS_OFF_TWTR) twtr <= wmerge(twtr, w_data, w_strb) & 32'h0000ffff;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [5:0] rd_addr = {s_axi_araddr[5:2], 2'b00};
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DWS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DWS_RESP_OKAY;
      case (rd_addr)
        `DWS_OFF_CTRL:     s_axi_rdata <= ctrl;
        `DWS_OFF_LAT:      s_axi_rdata <= lat;
        `DWS_OFF_TWTR:     s_axi_rdata <= twtr;
        `DWS_OFF_STATUS:   s_axi_rdata <= {28'h0000000, busy, wtr_err, space_err, cfg_err};
        `DWS_OFF_BEATS:    s_axi_rdata <= {16'h0000, beat_cnt};
        `DWS_OFF_LASTDATA: s_axi_rdata <= {16'h0000, last_data};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `DWS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dws_write_path

// ==== dws_checker.sv ====
// port assertions for the write burst path
`timescale 1ns/1ps
module dws_checker (
  input wire        aclk,          // clock
  input wire        aresetn,       // reset
  input wire        s_axi_awready, // aw ready
  input wire [1:0]  s_axi_bresp,   // b resp
  input wire        s_axi_bvalid,  // b valid
  input wire        s_axi_bready,  // b ready
  input wire        s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata,   // r data
  input wire        s_axi_rvalid,  // r valid
  input wire        s_axi_rready,  // r ready
  input wire        beat_valid,    // beat
  input wire        beat_last,     // last beat
  input wire        burst_bl8,     // bl8
  input wire        rec_start      // recovery
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] nbeat;
  logic [5:0] since;
  // since saturates so a stray recovery pulse far from any burst end still fails
  always @(posedge aclk) begin
    if (!aresetn) begin
      nbeat <= 4'h0;
      since <= 6'h3f;
    end else begin
      if (beat_valid)
        nbeat <= beat_last ? 4'h0 : nbeat + 4'h1;
      since <= beat_last ? 6'h00 : (since == 6'h3f ? since : since + 6'h01);
    end
  end
  a_burst_beats: assert property (beat_last |-> nbeat == (burst_bl8 ? 4'h7 : 4'h3))
    else $error("burst beat count wrong");
  a_beat_pulse: assert property (beat_valid |=> !beat_valid [*8])
    else $error("beat pulse too long");
  a_beat_stream: assert property (beat_valid && !beat_last |-> ##[18:22] beat_valid)
    else $error("gap inside burst");
  a_rec_point: assert property (rec_start |-> since inside {[6'h10:6'h16]})
    else $error("recovery not one half ck after last beat");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  c_bl8: cover property (beat_last && burst_bl8);
  c_bc4: cover property (beat_last && !burst_bl8);
  c_rec: cover property (rec_start);
endmodule // dws_checker
bind dws_write_path dws_checker i_dws_checker (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .beat_valid, .beat_last,
  .burst_bl8, .rec_start);

// ==== dws_ctrl_model.sv ====
// controller model: link clock only within frames, commands and changing data
`timescale 1ns/1ps
module dws_ctrl_model (
  output logic        ck_pin, // link clock
  output logic        cs_n,   // select
  output logic        act_n,  // activate
  output logic        ras_n,  // row strobe
  output logic        cas_n,  // column strobe
  output logic        we_n,   // write enable
  output logic        a12,    // chop select
  output logic        bg,     // bank group
  output logic [15:0] dq      // data
);
  logic [15:0] edge_n = 16'h0000;
  initial begin
    {ck_pin, cs_n, act_n, ras_n, cas_n, we_n, a12, bg} = 8'h7c;
    dq = 16'h0000;
  end
  // one ck period; 0 deselect, 1 write, 2 read, 3 precharge
  // any command in any slot
  task automatic tick(input logic [1:0] c, input logic a, input logic g);
    cs_n = (c == 2'h0);
    {act_n, ras_n, cas_n, we_n} = (c == 2'h3) ? 4'ha : {3'h6, c != 2'h1};
    a12 = a;
    bg = g;
    dq = edge_n;
    #40 ck_pin = 1'b1;
    #40 dq = edge_n + 16'h0001;
    #40 ck_pin = 1'b0;
    #40 edge_n = edge_n + 16'h0002;
  endtask
endmodule // dws_ctrl_model

// ==== dws_write_path_tb_top.sv ====
// top bench: register access and write traffic from the controller model
`timescale 1ns/1ps
`include "dws_defs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module dws_write_path_tb_top;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  rr;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         ck_pin, cs_n, act_n, ras_n, cas_n, we_n, a12, bg;
  wire [15:0]  dq, beat_data;
  wire         beat_valid, beat_last, burst_bl8, rec_start, other_cmd;
  int          mismatches = 0, total_checks = 0, cycles = 0, seed = 21917, t = 0;
  int          n_beat = 0, n_last = 0, n_oth = 0, rec_t = 0, eb = 0;
  logic [15:0] lb = 16'h0000;
  dws_write_path i_dws_write_path (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ck_pin, .cs_n,
    .act_n, .ras_n, .cas_n, .we_n, .a12, .bg, .dq, .beat_valid, .beat_data, .beat_last, .burst_bl8, .rec_start,
    .other_cmd);
  dws_ctrl_model i_dws_ctrl_model (.ck_pin, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .a12, .bg, .dq);
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (aresetn) begin
      n_beat <= n_beat + beat_valid;
      n_last <= n_last + beat_last;
      n_oth <= n_oth + other_cmd;
      if (rec_start)
        rec_t <= t;
      if (beat_last)
        lb <= beat_data;
    end
    if (cycles == 40000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
  endtask
  task automatic rdr(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    rdr(a);
    `CHK("rdata", e, rd)
    `CHK("rresp", er, rr)
  endtask
  task automatic stchk(input logic [2:0] e);
    rdr(`DWS_OFF_STATUS);
    `CHK("status", e, rd[2:0])
    wr(`DWS_OFF_STATUS, 32'h6, `DWS_RESP_OKAY);
  endtask
  task automatic cfg(input logic [31:0] c, input logic [5:0] al, input logic [5:0] cwl);
    wr(`DWS_OFF_CTRL, c, `DWS_RESP_OKAY);
    wr(`DWS_OFF_LAT, {10'h0, 6'h09, 2'h0, al, 2'h0, cwl}, `DWS_RESP_OKAY);
  endtask
  task automatic tk(input logic [1:0] c, input logic a, input logic g);
    i_dws_ctrl_model.tick(c, a, g);
    t++;
  endtask
  task automatic idle(input int n);
    repeat (n) tk(2'h0, 1'b0, 1'b0);
  endtask
  function automatic int nbeats(input logic [1:0] m, input logic a);
    return (m == `DWS_BL_FIXED8 || (m == `DWS_BL_OTF && a)) ? 8 : 4;
  endfunction
  // two writes gap ck apart, or one write for gap 0; ck stands still outside the frame
  task automatic pair(input int gap, input logic [1:0] m, input logic a0, input logic a1, input logic g1,
                      input int wl);
    int b, l, r, nb;
    b = n_beat;
    l = n_last;
    @(posedge aclk);
    #1;
    tk(2'h1, a0, 1'b0);
    if (gap > 0) begin
      idle(gap - 1);
      tk(2'h1, a1, g1);
    end
    r = t - 1;
    nb = nbeats(m, gap > 0 ? a1 : a0);
    idle(wl + 6);
    eb += nb + (gap > 0 ? nbeats(m, a0) : 0);
    `CHK("beats", nb + (gap > 0 ? nbeats(m, a0) : 0), n_beat - b)
    `CHK("lasts", 1 + (gap > 0), n_last - l)
    `CHK("recovery", r + wl + nb / 2, rec_t)
    rdr(`DWS_OFF_LASTDATA);
    `CHK("lastdata", {16'h0, 16'(2 * (r + wl) + nb - 1)}, rd)
    `CHK("beatdata", 16'(2 * (r + wl) + nb - 1), lb)
  endtask
  // write, precharge in mid-burst, then a read gap ck after the recovery point
  task automatic wtr(input logic g, input int gap, input logic [2:0] e);
    int o;
    o = n_oth;
    @(posedge aclk);
    #1;
    tk(2'h1, 1'b1, 1'b0);
    idle(9);
    tk(2'h3, 1'b0, 1'b0);
    idle(gap + 2);
    tk(2'h2, 1'b0, g);
    idle(2);
    eb += 8;
    `CHK("others", 2, n_oth - o)
    stchk(e);
  endtask
  initial begin
    logic [1:0] m;
    logic [5:0] al;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`DWS_OFF_CTRL, `DWS_RST_CTRL, `DWS_RESP_OKAY);
    rchk(`DWS_OFF_LAT, `DWS_RST_LAT, `DWS_RESP_OKAY);
    rchk(`DWS_OFF_TWTR, `DWS_RST_TWTR, `DWS_RESP_OKAY);
    rchk(6'h18, 32'h0, `DWS_RESP_SLVERR);
    wr(6'h1c, 32'h0, `DWS_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      m = i[2:1];
      al = 6'($random(seed) & 3);
      cfg({30'h0, m}, al, 6'h09);
      pair(0, m, i[0], 1'b0, 1'b0, 9 + al);
      stchk(3'h0);
    end
    cfg({30'h0, `DWS_BL_OTF}, 6'h0, 6'h09);
    pair(4, `DWS_BL_OTF, 1'b1, 1'b1, 1'b1, 9);
    pair(4, `DWS_BL_OTF, 1'b1, 1'b0, 1'b1, 9);
    pair(5, `DWS_BL_OTF, 1'b1, 1'b1, 1'($random(seed)), 9);
    stchk(3'h0);
    cfg(32'h1 << `DWS_CTRL_PRE2, 6'h0, 6'h09);
    stchk(3'h1);
    cfg(32'h1 << `DWS_CTRL_PRE2, 6'h0, 6'h0a);
    pair(6, `DWS_BL_FIXED8, 1'b0, 1'b0, 1'($random(seed)), 10);
    stchk(3'h0);
    pair(5, `DWS_BL_FIXED8, 1'b0, 1'b0, 1'b1, 10);
    stchk(3'h2);
    stchk(3'h0);
    cfg(32'h0, 6'h0, 6'h09);
    wtr(1'b0, 6, 3'h0);
    wtr(1'b0, 5, 3'h4);
    wtr(1'b1, 2, 3'h0);
    wtr(1'b1, 1, 3'h4);
    rdr(`DWS_OFF_BEATS);
    `CHK("beat total", 16'(eb), rd[15:0])
    `CHK("beat count", eb, n_beat)
    final_report();
  end
endmodule // dws_write_path_tb_top
